// ===== inc/power_mode_pkg.sv
// constants, modes and register map of the power mode controller
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------
// Summary of operation
// - oscillator input divided by two for internal states
// - idle stops cpu, peripherals keep running
// - idle keeps ram and function registers unchanged
// - enabled interrupt or reset ends idle
// - reset from idle: ram writes blocked, ports not
// - power down stops oscillator, last instruction executed
// - power down keeps ram and function registers
// - reset ends power down, reinits registers, keeps ram
// - external interrupt wake keeps registers and ram
// - level wake pin low restarts oscillator, high exits
// - after wake handler, continue after power down instruction
// - strobes high in idle, low in power down
// - emulation state floats port0, weak pulls, oscillator runs
// - only a normal reset leaves emulation state
// - reset pin high two machine cycles resets
// - address strobe at osc/6, skip on data access
package power_mode_pkg;

	//------------------------------------------------------------------
	// register map (byte addresses, one word each)
	//------------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] PCON_OFS = 8'h00;
	localparam logic [7:0] WAKE_CFG_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;

	//------------------------------------------------------------------
	// field positions and reset values
	//------------------------------------------------------------------
	localparam int unsigned PCON_IDLE_BIT = 0;
	localparam int unsigned PCON_PDOWN_BIT = 1;
	localparam logic [1:0] PCON_RESET = 2'h0;
	localparam int unsigned WAKE_EN_LSB = 0;
	localparam int unsigned WAKE_LVL_LSB = 2;
	localparam logic [3:0] WAKE_CFG_RESET = 4'h0;
	localparam int unsigned STAT_MODE_LSB = 0;
	localparam int unsigned STAT_RESET_BIT = 3;
	localparam int unsigned STAT_RAMBLK_BIT = 4;
	localparam int unsigned STAT_ONCE_BIT = 5;

	//------------------------------------------------------------------
	// timing counts, in internal states (two oscillator periods each)
	//------------------------------------------------------------------
	localparam logic [2:0] STATES_PER_MC = 3'h6;
	localparam logic [3:0] RESET_MC = 4'h2;
	localparam logic [3:0] RESET_STATES = 4'(4'(STATES_PER_MC) * RESET_MC);
	localparam logic [2:0] ALE_STATE_A = 3'h0;
	localparam logic [2:0] ALE_STATE_B = 3'h3;

	//------------------------------------------------------------------
	// operating modes
	//------------------------------------------------------------------
	typedef enum logic [2:0] {
		st_run,
		st_idle,
		st_pdown,
		st_pd_wake,
		st_once
	} pmode_t;

endpackage : power_mode_pkg

// ===== logic/mcu_power_mode_control.sv
// idle, power down and emulation state control with apb registers
`timescale 1ns/1ps

module mcu_power_mode_control
	import power_mode_pkg::*;
(
	input logic ref_clk,
	input logic rst,
	// apb slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// oscillator
	input logic osc_input,
	output logic osc_output,
	// pins and system inputs
	input logic reset_pin,
	input logic ext_irq_zero_n,
	input logic ext_irq_one_n,
	input logic irq_pending,
	input logic xdata_access,
	input logic ext_prog_mem,
	input logic ale_i,
	output logic ale_o,
	output logic ale_oe,
	input logic program_fetch_strobe_i,
	output logic program_fetch_strobe_o,
	output logic program_fetch_strobe_oe,
	// core control
	output logic state_en,
	output logic cpu_run,
	output logic periph_run,
	output logic ram_write_en,
	output logic special_function_regs_wr_en,
	output logic special_function_regs_reinit,
	output logic resume_next,
	output logic port0_float,
	output logic port2_addr_sel,
	output logic port_hold,
	output logic port_weak_pull,
	output logic once_active
);

	//------------------------------------------------------------------
	// declarations
	//------------------------------------------------------------------
	pmode_t mode_q, mode_d;
	logic osc_in_q;
	logic div_q;
	logic osc_run;
	logic osc_rise;
	logic osc_out_q;
	logic [2:0] state_idx_q;
	logic [3:0] rst_cnt_q;
	logic int_reset_q;
	logic once_arm_q;
	logic ram_block_q;
	logic resume_q;
	logic ale_q, ale_d;
	logic pfs_q, pfs_d;
	logic [1:0] pcon_q;
	logic [3:0] cfg_q;
	logic [DATA_W-1:0] prdata_q;
	logic [1:0] ext_irq_pin_n;
	logic [1:0] wake_line;
	logic wake_low;
	logic in_idle, in_pd, in_once;
	logic fetch_state, ale_state;
	logic wr_en, setup_rd;
	logic hit_pcon, hit_cfg, hit_stat, hit_any;
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] stat_word;
	logic leave_pd_irq;

	//------------------------------------------------------------------
	// oscillator and divide-by-two state clock
	//------------------------------------------------------------------
	assign osc_run = (mode_q != st_pdown);
	assign osc_rise = osc_run & osc_input & ~osc_in_q;
	assign state_en = osc_rise & div_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			osc_in_q <= 1'b0;
			div_q <= 1'b0;
			osc_out_q <= 1'b0;
		end else begin
			osc_in_q <= osc_input;
			osc_out_q <= osc_run & ~osc_input;
			if (osc_rise) begin
				div_q <= ~div_q;
			end
		end
	end

	assign osc_output = osc_out_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_idx_q <= 3'h0;
		end else if (state_en) begin
			state_idx_q <= (state_idx_q == STATES_PER_MC - 3'h1) ? 3'h0 : state_idx_q + 3'h1;
		end
	end

	//------------------------------------------------------------------
	// reset pin qualification and emulation entry
	//------------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rst_cnt_q <= 4'h0;
			int_reset_q <= 1'b0;
			once_arm_q <= 1'b0;
		end else begin
			if (!reset_pin) begin
				rst_cnt_q <= 4'h0;
			end else if (state_en && rst_cnt_q != RESET_STATES) begin
				rst_cnt_q <= rst_cnt_q + 4'h1;
			end
			int_reset_q <= reset_pin && (rst_cnt_q == RESET_STATES);
			if (!int_reset_q) begin
				once_arm_q <= 1'b0;
			end else begin
				once_arm_q <= !ale_i && program_fetch_strobe_i;
			end
		end
	end

	//------------------------------------------------------------------
	// wake lines: enabled and level-sensitive external pins
	//------------------------------------------------------------------
	assign ext_irq_pin_n = {ext_irq_one_n, ext_irq_zero_n};

	for (genvar gi = 0; gi < 2; gi++) begin : g_wake
		assign wake_line[gi] = cfg_q[WAKE_EN_LSB+gi] & cfg_q[WAKE_LVL_LSB+gi]
			& ~ext_irq_pin_n[gi];
	end

	assign wake_low = |wake_line;

	//------------------------------------------------------------------
	// mode state machine
	//------------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			st_run: begin
				if (pcon_q[PCON_PDOWN_BIT]) begin
					mode_d = st_pdown;
				end else if (pcon_q[PCON_IDLE_BIT]) begin
					mode_d = st_idle;
				end
			end
			st_idle: begin
				if (reset_pin || irq_pending) begin
					mode_d = st_run;
				end
			end
			st_pdown: begin
				if (reset_pin || wake_low) begin
					mode_d = st_pd_wake;
				end
			end
			st_pd_wake: begin
				if (!reset_pin && !wake_low) begin
					mode_d = st_run;
				end
			end
			st_once: begin
				mode_d = st_once;
			end
			default: begin
				mode_d = st_run;
			end
		endcase
		if (int_reset_q) begin
			mode_d = (!reset_pin && once_arm_q && !ale_i) ? st_once : st_run;
		end
	end

	assign leave_pd_irq = (mode_q == st_pd_wake) && !reset_pin && !wake_low && !int_reset_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_q <= st_run;
			ram_block_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			ram_block_q <= ((mode_q == st_idle) && reset_pin)
				|| (ram_block_q && reset_pin && !int_reset_q);
			resume_q <= leave_pd_irq;
		end
	end

	//------------------------------------------------------------------
	// core control outputs
	//------------------------------------------------------------------
	assign in_idle = (mode_q == st_idle);
	assign in_pd = (mode_q == st_pdown) || (mode_q == st_pd_wake);
	assign in_once = (mode_q == st_once);

	assign cpu_run = (mode_q == st_run) && !int_reset_q;
	assign periph_run = !in_pd;
	assign special_function_regs_wr_en = cpu_run;
	assign ram_write_en = cpu_run && !ram_block_q;
	assign special_function_regs_reinit = int_reset_q;
	assign resume_next = resume_q;
	assign once_active = in_once;

	//------------------------------------------------------------------
	// external bus pins per mode
	//------------------------------------------------------------------
	assign ale_state = (state_idx_q == ALE_STATE_A) || (state_idx_q == ALE_STATE_B);
	assign fetch_state = !ale_state;

	always_comb begin
		if (in_idle) begin
			ale_d = 1'b1;
			pfs_d = 1'b1;
		end else if (in_pd) begin
			ale_d = 1'b0;
			pfs_d = 1'b0;
		end else begin
			ale_d = ale_state && !(xdata_access && state_idx_q == ALE_STATE_A);
			pfs_d = !(ext_prog_mem && fetch_state && !xdata_access);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ale_q <= 1'b0;
			pfs_q <= 1'b1;
		end else begin
			ale_q <= ale_d;
			pfs_q <= pfs_d;
		end
	end

	assign ale_o = ale_q;
	assign program_fetch_strobe_o = pfs_q;
	assign ale_oe = !in_once && !int_reset_q;
	assign program_fetch_strobe_oe = !in_once;
	assign port0_float = in_once || ((in_idle || in_pd) && ext_prog_mem);
	assign port2_addr_sel = ext_prog_mem && !in_pd && !in_once;
	assign port_hold = in_idle || in_pd;
	assign port_weak_pull = in_once;

	//------------------------------------------------------------------
	// apb register slave, zero wait states
	//------------------------------------------------------------------
	assign hit_pcon = (paddr == PCON_OFS);
	assign hit_cfg = (paddr == WAKE_CFG_OFS);
	assign hit_stat = (paddr == STATUS_OFS);
	assign hit_any = hit_pcon || hit_cfg || hit_stat;
	assign wr_en = psel && penable && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	assign stat_word = DATA_W'({in_once, ram_block_q, int_reset_q, 3'(mode_q)});
	assign rd_word = hit_pcon ? DATA_W'(pcon_q)
		: hit_cfg ? DATA_W'(cfg_q)
		: hit_stat ? stat_word
		: '0;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pcon_q <= PCON_RESET;
			cfg_q <= WAKE_CFG_RESET;
			prdata_q <= '0;
		end else begin
			if (int_reset_q) begin
				pcon_q <= PCON_RESET;
				cfg_q <= WAKE_CFG_RESET;
			end else begin
				if (wr_en && hit_pcon) begin
					pcon_q <= pwdata[1:0];
				end else if ((in_idle || in_pd) && mode_d == st_run) begin
					pcon_q <= PCON_RESET;
				end
				if (wr_en && hit_cfg) begin
					cfg_q <= pwdata[3:0];
				end
			end
			if (setup_rd) begin
				prdata_q <= rd_word;
			end
		end
	end

	assign prdata = prdata_q;

	//------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------
	localparam int RESET_MIN_CYC = 40;
	logic [6:0] hi_cnt_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hi_cnt_q <= 7'h00;
		end else if (!reset_pin) begin
			hi_cnt_q <= 7'h00;
		end else if (hi_cnt_q != 7'h7F) begin
			hi_cnt_q <= hi_cnt_q + 7'h01;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_pd_wins: assert property (
		(mode_q == st_run) && !int_reset_q && (pcon_q == 2'h3) |=> (mode_q == st_pdown))
		else $error("power down did not win over idle");
	chk_idle_cpu: assert property (
		in_idle |-> !cpu_run && periph_run && !ram_write_en)
		else $error("idle did not stop cpu only");
	chk_idle_strobes: assert property (
		in_idle |=> ale_o && program_fetch_strobe_o)
		else $error("strobes not high in idle");
	chk_pd_strobes: assert property (
		in_pd |=> !ale_o && !program_fetch_strobe_o)
		else $error("strobes not low in power down");
	chk_pd_osc_stop: assert property (
		(mode_q == st_pdown) |-> !state_en ##1 !osc_output)
		else $error("oscillator runs in power down");
	chk_pd_hold: assert property (
		in_pd |-> !ram_write_en && !special_function_regs_wr_en && !periph_run)
		else $error("state writable in power down");
	chk_ram_block: assert property (
		in_idle && reset_pin |=> !ram_write_en [*2])
		else $error("ram write during reset from idle");
	chk_idle_wake: assert property (
		in_idle && irq_pending && !int_reset_q |=> (mode_q == st_run) ##1 !pcon_q[PCON_IDLE_BIT])
		else $error("interrupt did not end idle");
	chk_resume_pulse: assert property (
		leave_pd_irq |=> resume_next && (mode_q == st_run) ##1 !resume_next)
		else $error("resume pulse missing after wake");
	chk_reset_len: assert property (
		$rose(int_reset_q) |-> $past(reset_pin) && (hi_cnt_q >= 7'(RESET_MIN_CYC)))
		else $error("internal reset too early");
	chk_once_pins: assert property (
		in_once |-> port0_float && port_weak_pull && !ale_oe && osc_run)
		else $error("emulation pins wrong");
	chk_once_stays: assert property (
		in_once && !int_reset_q |=> in_once)
		else $error("emulation left without reset");

	cov_idle_entry: cover property ((mode_q == st_run) ##1 in_idle);
	cov_pd_irq_exit: cover property ((mode_q == st_pdown) ##[1:200] resume_next);
	cov_once_entry: cover property (int_reset_q ##1 in_once);
	cov_idle_reset: cover property (in_idle && reset_pin ##1 ram_block_q);

endmodule : mcu_power_mode_control

// ===== bench/ext_bus_emulator.sv
// far side model: clock source and emulator on the strobe pins
`timescale 1ns/1ps

module ext_bus_emulator (
	input wire logic ref_clk,
	input wire logic pull_ale_low,
	input wire logic ale_o,
	input wire logic ale_oe,
	input wire logic pfs_o,
	input wire logic pfs_oe,
	output logic osc_input,
	output logic ale_i,
	output logic pfs_i
);
	logic [1:0] div_q = 2'h0;

	// free running source, each level lasts two reference cycles
	always @(posedge ref_clk) begin
		div_q <= div_q + 2'h1;
	end
	assign osc_input = div_q[1];
	// tester overdrives the strobe; released pins sit on their pull-ups
	assign ale_i = pull_ale_low ? 1'b0 : (ale_oe ? ale_o : 1'b1);
	assign pfs_i = pfs_oe ? pfs_o : 1'b1;
endmodule : ext_bus_emulator

// ===== bench/mcu_power_mode_control_tb_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps

module mcu_power_mode_control_tb_top;
	import power_mode_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic reset_pin = 1'b0;
	logic ext_irq_zero_n = 1'b1;
	logic ext_irq_one_n = 1'b1;
	logic irq_pending = 1'b0;
	logic xdata_access = 1'b0;
	logic ext_prog_mem = 1'b0;
	logic pull_ale_low = 1'b0;
	logic [DATA_W-1:0] prdata;
	logic [DATA_W-1:0] rd;
	logic pready, pslverr, osc_input, osc_output, err, prev;
	logic ale_i, ale_o, ale_oe, pfs_i, pfs_o, pfs_oe;
	logic state_en, cpu_run, periph_run, ram_write_en, special_function_regs_wr_en;
	logic special_function_regs_reinit;
	logic resume_next, port0_float, port2_addr_sel, port_hold, port_weak_pull, once_active;
	int num_errors = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	int cnt, cnt2;

	always #20 ref_clk = ~ref_clk;

	mcu_power_mode_control i_mcu_power_mode_control (
		.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .osc_input, .osc_output, .reset_pin, .ext_irq_zero_n, .ext_irq_one_n,
		.irq_pending, .xdata_access, .ext_prog_mem, .ale_i, .ale_o, .ale_oe,
		.program_fetch_strobe_i(pfs_i),
		.program_fetch_strobe_o(pfs_o),
		.program_fetch_strobe_oe(pfs_oe),
		.state_en, .cpu_run, .periph_run, .ram_write_en, .special_function_regs_wr_en,
		.special_function_regs_reinit,
		.resume_next, .port0_float, .port2_addr_sel, .port_hold, .port_weak_pull,
		.once_active
	);

	ext_bus_emulator i_ext_bus_emulator (
		.ref_clk, .pull_ale_low, .ale_o, .ale_oe, .pfs_o, .pfs_oe, .osc_input, .ale_i,
		.pfs_i
	);

	//------------------------------------------------------------------
	// shared tasks
	//------------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : cyc

	task automatic mode(input logic [2:0] exp);
		apb(1'b0, STATUS_OFS, '0);
		chk("mode", rd[2:0], exp);
	endtask : mode

	// counts strobe rises over 48 internal states
	task automatic ale_rate(input int exp);
		cnt = 0;
		cnt2 = 0;
		// align the window to a state step so every counted step owns its strobe
		@(negedge ref_clk);
		while (state_en !== 1'b1) begin
			@(negedge ref_clk);
		end
		prev = ale_o;
		while (cnt2 < 48) begin
			@(negedge ref_clk);
			cnt2 += state_en;
			cnt += (ale_o && !prev);
			prev = ale_o;
		end
		chk("ale rate", cnt, exp);
	endtask : ale_rate

	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	//------------------------------------------------------------------
	// tests
	//------------------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, PCON_OFS, '0);
		chk("pcon", rd, 32'h0);
		apb(1'b1, 8'h0C, 32'hF);
		chk("slverr", err, 32'h1);
		$display("test registers done");
		cnt = 0;
		repeat (80) begin
			@(negedge ref_clk);
			cnt += state_en;
		end
		chk("state rate", cnt, 32'hA);
		ale_rate(16);
		@(posedge ref_clk);
		xdata_access <= 1'b1;
		ale_rate(8);
		@(posedge ref_clk);
		xdata_access <= 1'b0;
		ext_prog_mem <= 1'b1;
		$display("test strobes done");
		apb(1'b1, PCON_OFS, 32'h1);
		cyc(3);
		chk("cpu idle", cpu_run, 32'h0);
		chk("hold idle", port_hold, 32'h1);
		chk("regs wr idle", special_function_regs_wr_en, 32'h0);
		chk("periph", periph_run, 32'h1);
		chk("ale idle", ale_o, 32'h1);
		chk("pfs idle", pfs_o, 32'h1);
		chk("p0 idle", port0_float, 32'h1);
		chk("p2 idle", port2_addr_sel, 32'h1);
		mode(3'h1);
		@(posedge ref_clk);
		irq_pending <= 1'b1;
		@(posedge ref_clk);
		irq_pending <= 1'b0;
		cyc(2);
		chk("cpu wake", cpu_run, 32'h1);
		apb(1'b0, PCON_OFS, '0);
		chk("pcon clr", rd, 32'h0);
		$display("test idle done");
		apb(1'b1, PCON_OFS, 32'h1);
		cyc(3);
		@(posedge ref_clk);
		reset_pin <= 1'b1;
		cnt = 0;
		for (int i = 0; i < 200; i++) begin
			@(negedge ref_clk);
			if (special_function_regs_reinit === 1'b1) break;
			cnt += state_en;
			if (i == 3) begin
				chk("cpu rst", cpu_run, 32'h1);
				chk("ram blk", ram_write_en, 32'h0);
			end
		end
		chk("rst states", cnt, 32'hC);
		@(posedge ref_clk);
		reset_pin <= 1'b0;
		cyc(3);
		chk("rst end", special_function_regs_reinit, 32'h0);
		mode(3'h0);
		$display("test reset done");
		apb(1'b1, WAKE_CFG_OFS, 32'h5);
		apb(1'b1, PCON_OFS, 32'h3);
		cyc(3);
		chk("osc stop", osc_output, 32'h0);
		chk("cpu pd", cpu_run, 32'h0);
		chk("ale pd", ale_o, 32'h0);
		chk("pfs pd", pfs_o, 32'h0);
		chk("p0 pd", port0_float, 32'h1);
		chk("p2 pd", port2_addr_sel, 32'h0);
		mode(3'h2);
		@(posedge ref_clk);
		ext_irq_zero_n <= 1'b0;
		cyc(3);
		mode(3'h3);
		@(posedge ref_clk);
		ext_irq_zero_n <= 1'b1;
		cnt = 0;
		cnt2 = 0;
		repeat (8) begin
			@(negedge ref_clk);
			cnt += resume_next;
			cnt2 += special_function_regs_reinit;
		end
		chk("resume", cnt, 32'h1);
		chk("no reinit", cnt2, 32'h0);
		apb(1'b0, WAKE_CFG_OFS, '0);
		chk("wake kept", rd, 32'h5);
		mode(3'h0);
		$display("test power down done");
		@(posedge ref_clk);
		ext_prog_mem <= 1'b0;
		reset_pin <= 1'b1;
		pull_ale_low <= 1'b1;
		cyc(120);
		@(posedge ref_clk);
		reset_pin <= 1'b0;
		cyc(3);
		chk("once", once_active, 32'h1);
		chk("p0 once", port0_float, 32'h1);
		chk("weak", port_weak_pull, 32'h1);
		chk("ale oe once", ale_oe, 32'h0);
		chk("pfs oe once", pfs_oe, 32'h0);
		prev = osc_output;
		cyc(2);
		chk("osc once", osc_output, !prev);
		@(posedge ref_clk);
		pull_ale_low <= 1'b0;
		cyc(10);
		chk("once kept", once_active, 32'h1);
		@(posedge ref_clk);
		reset_pin <= 1'b1;
		cyc(120);
		@(posedge ref_clk);
		reset_pin <= 1'b0;
		cyc(3);
		chk("once left", once_active, 32'h0);
		$display("test emulation done");
		print_verdict();
	end
endmodule : mcu_power_mode_control_tb_top
